// file: logic/stop_mode_pkg.sv
// Package: constants, types and register map of the stop mode control block
// Function
// - Time-base idle/sleep exits on source clock fall
// - Setting stop bit 7 enters deep-stop
// - Deep-stop halts both oscillators and all operation
// - State retained; port latch follows hold enable
// - Entry clears prescaler and divider to zero
// - Stopped program counter holds address plus two
// - Reset ends stop; warm-up then single-clock run
// - Three wake sources: pin, key-on, voltage detect
// - Release select one: high wake level releases
// - Level mode: wake pin high blocks entry
// - Warm-up clock follows entry clock, not select
// - Wake pin low during warm-up no re-stop
// - Wake pin shared with port bit and interrupt
// - Modes grouped into four families
// - Release select zero: rising wake edge releases
// - Edge mode enters stop even with pin high
// - After wake, resume prior mode at next instruction
package stop_mode_pkg;

  // ==========================================================
  // Register map (word offsets on the bus)
  // ==========================================================
  localparam logic [3:0] OFS_SYSTEM_CONTROL_ONE = 4'h0; // Stop control
  localparam logic [3:0] OFS_MODE_CONTROL       = 4'h1; // Mode request
  localparam logic [3:0] OFS_WARMUP_CONTROL     = 4'h2; // Warm-up select
  localparam logic [3:0] OFS_WARMUP_VALUE       = 4'h3; // Warm-up count
  localparam logic [3:0] OFS_TIME_BASE_CONTROL  = 4'h4; // Time base select
  localparam logic [3:0] OFS_STATUS             = 4'h5; // Read-only status
  localparam logic [3:0] OFS_PROG_COUNT         = 4'h6; // Held PC

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int BIT_STOP       = 7; // Stop request
  localparam int BIT_RELEASE_MODE_SELECT       = 6; // Release mode select
  localparam int BIT_OUT_HOLD   = 4; // Port output hold enable
  localparam int BIT_WUC_SEL    = 1; // Warm-up clock select
  localparam int BIT_TB_IDLE    = 0; // Time-base idle request
  localparam int BIT_SLOW       = 1; // Slow (quarter low clock) request
  localparam int BIT_DUAL       = 2; // Dual-clock operation

  // ==========================================================
  // Reset values and counts
  // ==========================================================
  localparam logic [7:0]  RST_SYSCTL   = 8'h00;
  localparam logic [7:0]  RST_WUC_VAL  = 8'h00;
  localparam logic [15:0] PC_STOP_STEP = 16'h0002; // Two addresses on
  localparam logic [1:0]  QUARTER_DIV  = 2'h3;     // Quarter of low clock

  // Mode families and members
  typedef enum logic [3:0] {
    M_SINGLE_CLOCK_RUN = 4'h0, M_NORMAL2 = 4'h1,
    M_SLOW1   = 4'h2, M_SLOW2   = 4'h3,
    M_TIME_BASE_ONLY_IDLE   = 4'h4, M_IDLE1   = 4'h5, M_IDLE2 = 4'h6,
    M_LOW_CLOCK_TIME_BASE_SLEEP  = 4'h7, M_SLEEP1  = 4'h8
  } run_mode_t;

  typedef enum logic [1:0] {
    F_NORMAL = 2'h0, F_SLOW = 2'h1, F_IDLE = 2'h2, F_SLEEP = 2'h3
  } mode_family_t;

  // Sequencer states, Gray along run -> stop -> warm and run -> time-base idle -> run
  typedef enum logic [1:0] {
    S_RUN  = 2'b00,
    S_STOP = 2'b01,
    S_WARM = 2'b11,
    S_TBI  = 2'b10
  } seq_state_t;

  // Wake sources bundled together
  typedef struct packed {
    logic pin;      // Shared wake pin level
    logic key_on;   // Key-on wakeup request
    logic volt_det; // Voltage detection request
  } wake_src_t;

  // Clock gating outputs bundled together
  typedef struct packed {
    logic hf_osc_en; // High-frequency oscillator enable
    logic lf_osc_en; // Low-frequency oscillator enable
    logic core_en;   // Core and peripheral operation enable
    logic tb_en;     // Time base timer enable
  } clk_ctl_t;

endpackage : stop_mode_pkg

// file: logic/warmup_counter.sv
// Warm-up counter: counts a programmed value of enable ticks
module warmup_counter
  import stop_mode_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       start,   // Load and begin counting
  input  wire logic       tick,    // Selected source clock enable
  input  wire logic [7:0] value,   // Programmed warm-up count
  output logic            busy,    // Counting in progress
  output logic            done     // One-cycle completion pulse
);

  logic [7:0] cnt_r; // Remaining ticks

  // ==========================================================
  // Countdown
  // ==========================================================
  // Zero value still waits one tick so the oscillator gets a beat
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 8'h00;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_r <= value;
        busy  <= 1'b1;
      end else if (busy && tick) begin
        if (cnt_r == 8'h00 || cnt_r == 8'h01) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 8'h01;
        end
      end
    end
  end

endmodule : warmup_counter

// file: logic/stop_mode_power_control.sv
// Top: deep-stop and mode sequencer with a classic Wishbone slave
//
// Register access over Wishbone and the register addresses are this design's own decisions.
module stop_mode_power_control
  import stop_mode_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Reset sources that end deep-stop
  input  wire logic        ext_reset_req,
  input  wire logic        por_req,
  input  wire logic        volt_reset_req,
  // Wake sources
  input  wire wake_src_t   wake,
  // Clock enables from the clock tree
  input  wire logic        high_freq_tick,
  input  wire logic        low_freq_clock_tick,
  input  wire logic        time_base_src_clk,
  // CPU program counter of the stopping instruction
  input  wire logic [15:0] cpu_pc,
  // Outputs
  output clk_ctl_t         clk_ctl,
  output logic             prescaler_clear,
  output logic             port_latch_hold,
  output logic             shared_port_bit,
  output logic             shared_external_interrupt,
  output logic             resume_pulse,
  output logic             warmup_busy,
  output logic [3:0]       run_mode,
  output logic [1:0]       mode_family,
  output logic [15:0]      resume_pc
);

  // ==========================================================
  // Registers
  // ==========================================================
  logic [7:0]  system_control_one_r;   // Stop, release mode, hold
  logic [7:0]  mode_ctl_r;             // Idle, slow, dual requests
  logic [7:0]  warmup_counter_control_r; // Warm-up clock select
  logic [7:0]  warmup_count_value_r;   // Warm-up count
  logic [7:0]  time_base_control_r;    // Time base select (stored)
  seq_state_t  state_r;                // Sequencer state
  seq_state_t  state_nxt;
  run_mode_t   entry_mode_r;           // Mode in effect at stop entry
  run_mode_t   mode_r;                 // Current mode
  logic        reset_wake_r;           // Stop ended by a reset source
  logic        pin_d_r;                // Wake pin last sample
  logic        tb_d_r;                 // Time base clock last sample
  logic [1:0]  quarter_r;              // Low clock quarter divider
  logic        ack_r;                  // Bus acknowledge
  logic [15:0] pc_hold_r;              // Held program counter

  // Bus decode, reset, wake, time-base and warm-up nets
  logic        bus_req;
  logic        bus_wr;
  logic [3:0]  word_adr;
  logic        stop_wr;
  logic        rst_src;
  logic        wake_rise;
  logic        pin_wake;
  logic        any_wake;
  logic        tb_fall;
  logic        quarter_tick;
  logic        wuc_tick;
  logic        warm_start;
  logic        warm_done;
  logic        release_mode_select;

  assign bus_req  = wb_cyc_i && wb_stb_i && !ack_r;
  assign bus_wr   = bus_req && wb_we_i && wb_sel_i[0];
  assign word_adr = wb_adr_i[5:2];
  assign release_mode_select     = system_control_one_r[BIT_RELEASE_MODE_SELECT];
  assign rst_src  = ext_reset_req || por_req || volt_reset_req;

  // Stop request written by software this cycle
  assign stop_wr = bus_wr && (word_adr == OFS_SYSTEM_CONTROL_ONE) &&
                   wb_dat_i[BIT_STOP];

  // ==========================================================
  // Wake pin: one input serves port, interrupt and release
  // ==========================================================
  assign shared_port_bit           = pin_d_r;
  assign shared_external_interrupt = pin_d_r;
  assign wake_rise = wake.pin && !pin_d_r;
  // Level mode releases on high, edge mode on a rising edge
  assign pin_wake = release_mode_select ? wake.pin : wake_rise;
  assign any_wake = pin_wake || wake.key_on || wake.volt_det;

  // Falling edge of the chosen time base source clock
  assign tb_fall = tb_d_r && !time_base_src_clk;

  // Pin and time-base samples
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_d_r <= 1'b0;
      tb_d_r  <= 1'b0;
    end else begin
      pin_d_r <= wake.pin;
      tb_d_r  <= time_base_src_clk;
    end
  end

  // Quarter of the low-frequency clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      quarter_r <= 2'h0;
    end else if (low_freq_clock_tick) begin
      quarter_r <= quarter_r + 2'h1;
    end
  end
  assign quarter_tick = low_freq_clock_tick && (quarter_r == QUARTER_DIV);

  // ==========================================================
  // Warm-up clock choice
  // ==========================================================
  // After a stop wake the entry clock wins over the select field;
  // a reset always restarts on the high-frequency clock
  always_comb begin
    if (reset_wake_r) begin
      wuc_tick = high_freq_tick;
    end else if (entry_mode_r == M_SLOW1 || entry_mode_r == M_SLOW2) begin
      wuc_tick = quarter_tick;
    end else begin
      wuc_tick = high_freq_tick;
    end
  end

  warmup_counter u_warmup (
    .clk   (clk),
    .rst_n (rst_n),
    .start (warm_start),
    .tick  (wuc_tick),
    .value (warmup_count_value_r),
    .busy  (warmup_busy),
    .done  (warm_done)
  );

  // ==========================================================
  // Sequencer next state
  // ==========================================================
  always_comb begin
    state_nxt  = state_r;
    warm_start = 1'b0;
    case (state_r)
      S_RUN: begin
        if (stop_wr) begin
          // Level mode with pin high refuses entry
          if (!(wb_dat_i[BIT_RELEASE_MODE_SELECT] && wake.pin)) begin
            state_nxt = S_STOP;
          end
        end else if (mode_r == M_TIME_BASE_ONLY_IDLE || mode_r == M_LOW_CLOCK_TIME_BASE_SLEEP) begin
          state_nxt = S_TBI;
        end
      end
      S_STOP: begin
        // Only events from the first stop cycle count; a wake in the entry cycle is missed
        if (rst_src || any_wake) begin
          state_nxt  = S_WARM;
          warm_start = 1'b1;
        end
      end
      S_WARM: begin
        // Pin returning low has no say here
        if (warm_done) begin
          state_nxt = S_RUN;
        end
      end
      S_TBI: begin
        if (tb_fall) begin
          state_nxt = S_RUN;
        end
      end
      default: state_nxt = S_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= S_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Reason the stop ended, kept until warm-up finishes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_wake_r <= 1'b0;
    end else if (state_r == S_STOP && rst_src) begin
      reset_wake_r <= 1'b1;
    end else if (state_r == S_RUN) begin
      reset_wake_r <= 1'b0;
    end
  end

  // ==========================================================
  // Mode tracking
  // ==========================================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      entry_mode_r <= M_SINGLE_CLOCK_RUN;
      mode_r       <= M_SINGLE_CLOCK_RUN;
    end else if (state_r == S_RUN && state_nxt == S_STOP) begin
      entry_mode_r <= mode_r;
    end else if (state_r == S_WARM && warm_done) begin
      // Reset wake lands in single-clock run, else prior mode
      mode_r <= reset_wake_r ? M_SINGLE_CLOCK_RUN : entry_mode_r;
    end else if (state_r == S_TBI && tb_fall) begin
      mode_r <= (mode_r == M_LOW_CLOCK_TIME_BASE_SLEEP) ? M_SLOW1 : M_SINGLE_CLOCK_RUN;
    end else if (state_r == S_RUN) begin
      mode_r <= decode_mode(mode_ctl_r);
    end
  end

  // Requested mode from the mode control bits
  function automatic run_mode_t decode_mode(input logic [7:0] c);
    run_mode_t m;
    m = M_SINGLE_CLOCK_RUN;
    if (!c[BIT_DUAL]) begin
      m = c[BIT_TB_IDLE] ? M_TIME_BASE_ONLY_IDLE : M_SINGLE_CLOCK_RUN;
    end else if (c[BIT_SLOW]) begin
      m = c[BIT_TB_IDLE] ? M_LOW_CLOCK_TIME_BASE_SLEEP : M_SLOW1;
    end else begin
      m = M_NORMAL2;
    end
    return m;
  endfunction : decode_mode

  // Family of the current mode
  always_comb begin
    case (mode_r)
      M_SINGLE_CLOCK_RUN, M_NORMAL2:       mode_family = F_NORMAL;
      M_SLOW1, M_SLOW2:           mode_family = F_SLOW;
      M_TIME_BASE_ONLY_IDLE, M_IDLE1, M_IDLE2:  mode_family = F_IDLE;
      default:                    mode_family = F_SLEEP;
    endcase
  end
  assign run_mode = mode_r;

  // ==========================================================
  // Held program counter
  // ==========================================================
  // Captured on entry; data memory and registers hold by gating
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_hold_r <= 16'h0000;
    end else if (state_r == S_RUN && state_nxt == S_STOP) begin
      pc_hold_r <= cpu_pc + PC_STOP_STEP;
    end
  end
  assign resume_pc = pc_hold_r;

  // ==========================================================
  // Clock and operation gating
  // ==========================================================
  always_comb begin
    clk_ctl.hf_osc_en = !(mode_r == M_SLOW1 || mode_r == M_LOW_CLOCK_TIME_BASE_SLEEP);
    clk_ctl.lf_osc_en = (mode_r != M_SINGLE_CLOCK_RUN) && (mode_r != M_TIME_BASE_ONLY_IDLE);
    clk_ctl.core_en   = (state_r == S_RUN);
    clk_ctl.tb_en     = (state_r != S_STOP) && (state_r != S_WARM);
    if (state_r == S_STOP) begin
      clk_ctl.hf_osc_en = 1'b0;
      clk_ctl.lf_osc_en = 1'b0;
    end
    if (state_r == S_WARM) begin
      clk_ctl.hf_osc_en = reset_wake_r || clk_ctl.hf_osc_en;
      clk_ctl.core_en   = 1'b0;
    end
  end

  // Timing generator cleared on entry and held while stopped
  assign prescaler_clear = (state_r == S_STOP) ||
                           (state_r == S_WARM && warm_done);
  // In deep-stop port latches hold only when enabled, else they release
  assign port_latch_hold = (state_r != S_STOP) ||
                           system_control_one_r[BIT_OUT_HOLD];
  assign resume_pulse = (state_r == S_WARM) && warm_done;

  // ==========================================================
  // Register writes
  // ==========================================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      system_control_one_r     <= RST_SYSCTL;
      mode_ctl_r               <= 8'h00;
      warmup_counter_control_r <= 8'h00;
      warmup_count_value_r     <= RST_WUC_VAL;
      time_base_control_r      <= 8'h00;
    end else begin
      if (bus_wr) begin
        case (word_adr)
          OFS_SYSTEM_CONTROL_ONE: system_control_one_r <= wb_dat_i[7:0];
          OFS_MODE_CONTROL:       mode_ctl_r <= wb_dat_i[7:0];
          OFS_WARMUP_CONTROL:     warmup_counter_control_r <= wb_dat_i[7:0];
          OFS_WARMUP_VALUE:       warmup_count_value_r <= wb_dat_i[7:0];
          OFS_TIME_BASE_CONTROL:  time_base_control_r <= wb_dat_i[7:0];
          default: ;
        endcase
      end
      // Refused entry or finished stop drops the request bit
      if ((stop_wr && state_nxt != S_STOP) || resume_pulse) begin
        system_control_one_r[BIT_STOP] <= 1'b0;
      end
      // Idle request falls when time-base idle ends
      if (state_r == S_TBI && tb_fall) begin
        mode_ctl_r[BIT_TB_IDLE] <= 1'b0;
      end
      // Reset exit restores single-clock run
      if (resume_pulse && reset_wake_r) begin
        mode_ctl_r <= 8'h00;
      end
    end
  end

  // ==========================================================
  // Bus read and acknowledge
  // ==========================================================
  // One wait state: ack one cycle after the strobe, then drops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r    <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack_r <= bus_req;
      if (bus_req && !wb_we_i) begin
        case (word_adr)
          OFS_SYSTEM_CONTROL_ONE: wb_dat_o <= {24'h0, system_control_one_r};
          OFS_MODE_CONTROL:       wb_dat_o <= {24'h0, mode_ctl_r};
          OFS_WARMUP_CONTROL:
            wb_dat_o <= {24'h0, warmup_counter_control_r};
          OFS_WARMUP_VALUE:       wb_dat_o <= {24'h0, warmup_count_value_r};
          OFS_TIME_BASE_CONTROL:  wb_dat_o <= {24'h0, time_base_control_r};
          OFS_STATUS:
            wb_dat_o <= {20'h0, mode_r, 5'h00, warmup_busy, state_r};
          OFS_PROG_COUNT:         wb_dat_o <= {16'h0, pc_hold_r};
          default:                wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign wb_ack_o = ack_r;

endmodule : stop_mode_power_control

// file: sim/stop_mode_monitor.sv
// Checker: timing relations on the stop mode control ports
module stop_mode_monitor
  import stop_mode_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire wake_src_t   wake,
  input wire logic [15:0] cpu_pc,
  input wire clk_ctl_t    clk_ctl,
  input wire logic        prescaler_clear,
  input wire logic        shared_port_bit,
  input wire logic        shared_external_interrupt,
  input wire logic        resume_pulse,
  input wire logic        warmup_busy,
  input wire logic [15:0] resume_pc
);
  timeunit 1ns;
  timeprecision 1ns;
  // ====================
  // Helpers
  // ====================
  localparam int WARM_MAX = 1000; // Warm-up bound, far above the bench's longest run
  logic stop_now;                 // Deep-stop proper, resume cycle out
  assign stop_now = prescaler_clear & ~resume_pulse;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Warm-up has to finish; a stuck counter would hang the core
  sequence s_warm_done;
    warmup_busy ##[1:WARM_MAX] resume_pulse;
  endsequence
  // A wake source gets the warm-up going within two cycles
  sequence s_warm_start;
    ##[1:2] warmup_busy;
  endsequence
  // ====================
  // Assertions
  // ====================
  a_ack_answer: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
  a_stop_halts: assert property (
    stop_now |-> !clk_ctl.hf_osc_en && !clk_ctl.lf_osc_en
                 && !clk_ctl.core_en)
    else $error("clock or core running in deep-stop");
  a_stop_pc_held: assert property (
    stop_now |-> resume_pc == cpu_pc + PC_STOP_STEP)
    else $error("held program counter wrong in deep-stop");
  a_resume_clears: assert property (resume_pulse |-> prescaler_clear)
    else $error("prescaler not cleared on resume");
  a_pin_shared: assert property (
    1'b1 |=> shared_port_bit == $past(wake.pin)
             && shared_external_interrupt == $past(wake.pin))
    else $error("wake pin not routed to port and interrupt");
  a_pin_wake: assert property (
    stop_now && $rose(wake.pin) |-> s_warm_start)
    else $error("wake pin rise did not start warm-up");
  a_source_wake: assert property (
    stop_now && (wake.key_on || wake.volt_det) |-> s_warm_start)
    else $error("wake source did not start warm-up");
  a_warm_core_off: assert property (warmup_busy |-> !clk_ctl.core_en)
    else $error("core running during warm-up");
  a_warm_no_stop: assert property (warmup_busy |=> !stop_now)
    else $error("deep-stop re-entered during warm-up");
  a_warm_ends: assert property ($rose(warmup_busy) |-> s_warm_done)
    else $error("warm-up did not end with a resume pulse");
  a_resume_runs: assert property (
    resume_pulse |=> clk_ctl.core_en && !warmup_busy)
    else $error("core not running after resume");
endmodule : stop_mode_monitor

bind stop_mode_power_control stop_mode_monitor i_mon (
  .clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wake, .cpu_pc,
  .clk_ctl, .prescaler_clear, .shared_port_bit,
  .shared_external_interrupt, .resume_pulse, .warmup_busy, .resume_pc
);

// file: sim/wake_partner.sv
// Wake source model: wake pin, key-on, voltage detect, clock enables
module wake_partner
  import stop_mode_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  output wake_src_t wake,
  output logic      high_freq_tick,
  output logic      low_freq_clock_tick
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] div_r; // Free-running divider for the enables

  // All three wake sources idle low at start
  initial wake = '0;

  // Fast enable every second cycle, slow one every eighth
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 3'h0;
    end else begin
      div_r <= div_r + 3'h1;
    end
  end
  assign high_freq_tick      = div_r[0];
  assign low_freq_clock_tick = (div_r == 3'h7);

  // Pin, key-on and voltage detect; caller is just past an edge
  task automatic drive(input logic [2:0] v);
    wake <= v;
  endtask : drive
endmodule : wake_partner

// file: sim/stop_mode_power_control_tb_top.sv
// Testbench: deep-stop entry, wake and warm-up scenarios
module stop_mode_power_control_tb_top
  import stop_mode_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [5:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, run_mode;
  logic [31:0] wb_dat_i, wb_dat_o, rd_q;
  logic        ext_reset_req, por_req, volt_reset_req;
  logic        high_freq_tick, low_freq_clock_tick, time_base_src_clk;
  logic [15:0] cpu_pc, resume_pc;
  logic        prescaler_clear, port_latch_hold, shared_port_bit;
  logic        shared_external_interrupt, resume_pulse, warmup_busy;
  logic [1:0]  mode_family;
  wake_src_t   wake;
  clk_ctl_t    clk_ctl;
  int          failures, comparisons;

  stop_mode_power_control i_dut (
    .clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .ext_reset_req, .por_req,
    .volt_reset_req, .wake, .high_freq_tick, .low_freq_clock_tick,
    .time_base_src_clk, .cpu_pc, .clk_ctl, .prescaler_clear,
    .port_latch_hold, .shared_port_bit, .shared_external_interrupt,
    .resume_pulse, .warmup_busy, .run_mode, .mode_family, .resume_pc
  );
  wake_partner i_wake (.clk, .rst_n, .wake, .high_freq_tick,
                       .low_freq_clock_tick);

  // ====================
  // Shared tasks
  // ====================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test;
    if (failures == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask : step

  // Classic cycle: hold until ack is seen, then one idle cycle
  task automatic wb_xfer(input logic w, input logic [5:0] a,
                         input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      failures++;
      finish_test();
    end
    rd_q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask : wb_xfer

  // Stop request, then see whether deep-stop was taken
  task automatic enter_stop(input logic [7:0] v, input logic exp);
    wb_xfer(1'b1, {OFS_SYSTEM_CONTROL_ONE, 2'b00}, {24'h0, v});
    step(2);
    chk(prescaler_clear, exp);
  endtask : enter_stop

  // Warm-up length in cycles must land in a window
  task automatic wait_resume(input int lo, input int hi);
    int n;
    n = 0;
    while (resume_pulse !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 2000) begin
      failures++;
      finish_test();
    end
    chk(32'(n >= lo && n <= hi), 32'h1);
  endtask : wait_resume

  // ====================
  // Scenarios
  // ====================
  task automatic t_bus;
    wb_xfer(1'b0, 6'h3C, 32'h0);
    chk(rd_q, 32'h0); // Unmapped reads zero
    wb_xfer(1'b1, {OFS_STATUS, 2'b00}, 32'hFF);
    wb_xfer(1'b0, {OFS_STATUS, 2'b00}, 32'h0);
    chk(rd_q, 32'h0); // Status is read-only
    wb_sel_i <= 4'hE;
    wb_xfer(1'b1, {OFS_WARMUP_VALUE, 2'b00}, 32'h55);
    wb_sel_i <= 4'hF;
    wb_xfer(1'b0, {OFS_WARMUP_VALUE, 2'b00}, 32'h0);
    chk(rd_q, 32'h0); // Low byte lane off: write ignored
  endtask : t_bus

  task automatic t_tbi;
    wb_xfer(1'b1, {OFS_MODE_CONTROL, 2'b00}, 32'h01);
    step(2);
    chk(run_mode, M_TIME_BASE_ONLY_IDLE);
    chk(mode_family, F_IDLE);
    time_base_src_clk <= 1'b1;
    step(3);
    chk(clk_ctl.core_en, 1'b0);
    time_base_src_clk <= 1'b0;
    step(3);
    chk(run_mode, M_SINGLE_CLOCK_RUN);
  endtask : t_tbi

  task automatic t_edge;
    wb_xfer(1'b1, {OFS_WARMUP_VALUE, 2'b00}, 32'h04);
    i_wake.drive(3'b100);
    enter_stop(8'h80, 1'b1);
    chk(clk_ctl, 4'h0);
    chk(port_latch_hold, 1'b0);
    chk(resume_pc, 16'h1236);
    step(4);
    chk(prescaler_clear, 1'b1);
    i_wake.drive(3'b000);
    step(2);
    i_wake.drive(3'b100);
    step(2);
    chk(warmup_busy, 1'b1);
    i_wake.drive(3'b000);
    wait_resume(4, 14);
    step(1);
    wb_xfer(1'b0, {OFS_SYSTEM_CONTROL_ONE, 2'b00}, 32'h0);
    chk(rd_q[7], 1'b0);
    chk(run_mode, M_SINGLE_CLOCK_RUN);
  endtask : t_edge

  task automatic t_level;
    i_wake.drive(3'b100);
    enter_stop(8'hC0, 1'b0);
    chk(shared_external_interrupt, 1'b1);
    wb_xfer(1'b0, {OFS_SYSTEM_CONTROL_ONE, 2'b00}, 32'h0);
    chk(rd_q[7], 1'b0);
    i_wake.drive(3'b000);
    step(2);
    chk(shared_port_bit, 1'b0);
    cpu_pc <= 16'h2000;
    enter_stop(8'hD0, 1'b1);
    chk(port_latch_hold, 1'b1);
    chk(resume_pc, 16'h2002);
    i_wake.drive(3'b100);
    wait_resume(4, 14);
    i_wake.drive(3'b000);
  endtask : t_level

  task automatic t_slow;
    wb_xfer(1'b1, {OFS_WARMUP_VALUE, 2'b00}, 32'h04);
    wb_xfer(1'b1, {OFS_MODE_CONTROL, 2'b00}, 32'h06);
    step(2);
    chk(mode_family, F_SLOW);
    enter_stop(8'h80, 1'b1);
    i_wake.drive(3'b100);
    step(2);
    i_wake.drive(3'b000);
    wait_resume(97, 128);
    step(1);
    chk(mode_family, F_SLOW);
  endtask : t_slow

  task automatic t_sources;
    for (int i = 0; i < 5; i++) begin
      enter_stop(8'h80, 1'b1);
      case (i)
        0: i_wake.drive(3'b010);
        1: i_wake.drive(3'b001);
        2: ext_reset_req <= 1'b1;
        3: por_req <= 1'b1;
        default: volt_reset_req <= 1'b1;
      endcase
      step(2);
      i_wake.drive(3'b000);
      ext_reset_req  <= 1'b0;
      por_req        <= 1'b0;
      volt_reset_req <= 1'b0;
      wait_resume((i < 2) ? 97 : 4, (i < 2) ? 128 : 14);
      step(1);
      chk(run_mode, (i < 2) ? M_SLOW1 : M_SINGLE_CLOCK_RUN);
    end
  endtask : t_sources

  // ====================
  // Clock, reset, sequence
  // ====================
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, time_base_src_clk} = '0;
    {ext_reset_req, por_req, volt_reset_req} = '0;
    wb_adr_i    = 6'h00;
    wb_sel_i    = 4'hF;
    wb_dat_i    = 32'h0;
    cpu_pc      = 16'h1234;
    failures    = 0;
    comparisons = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_bus();
    t_tbi();
    t_edge();
    t_level();
    t_slow();
    t_sources();
    finish_test();
  end
endmodule : stop_mode_power_control_tb_top
